// ---- ctc_pkg.sv ----
// Package of constants for the compact timer core
package ctc_pkg;
  // ------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------
  localparam logic [7:0] CTC_ADR_CTRL_A = 8'h00;
  localparam logic [7:0] CTC_ADR_CTRL_B = 8'h04;
  localparam logic [7:0] CTC_ADR_CNT_LO = 8'h08;
  localparam logic [7:0] CTC_ADR_CNT_HI = 8'h0C;
  localparam logic [7:0] CTC_ADR_CMPA_LO = 8'h10;
  localparam logic [7:0] CTC_ADR_CMPA_HI = 8'h14;
  localparam logic [7:0] CTC_ADR_FLAGS = 8'h18;
  // ------------------------------------------------------------
  // Field positions, control A
  // ------------------------------------------------------------
  localparam int CTC_A_PAUSE = 7;
  localparam int CTC_A_CLK_HI = 6;
  localparam int CTC_A_CLK_LO = 4;
  localparam int CTC_A_ON = 3;
  localparam int CTC_A_PER_HI = 2;
  localparam int CTC_A_PER_LO = 0;
  // ------------------------------------------------------------
  // Field positions, control B and flags
  // ------------------------------------------------------------
  localparam int CTC_B_MODE_HI = 7;
  localparam int CTC_B_MODE_LO = 6;
  localparam int CTC_B_IO_HI = 5;
  localparam int CTC_B_IO_LO = 4;
  localparam int CTC_B_INIT = 3;
  localparam int CTC_B_POL = 2;
  localparam int CTC_B_CLR_SEL = 0;
  localparam int CTC_F_CMPA = 0;
  localparam int CTC_F_PER = 1;
  // ------------------------------------------------------------
  // Reset values and encodings
  // ------------------------------------------------------------
  localparam logic [7:0] CTC_CTRL_RST = 8'h00;
  localparam logic [9:0] CTC_CNT_RST = 10'h000;
  localparam logic [9:0] CTC_CNT_MAX = 10'h3FF;
  localparam logic [5:0] CTC_DIV4_MASK = 6'h03;
  localparam logic [5:0] CTC_DIV16_MASK = 6'h0F;
  localparam logic [5:0] CTC_DIV64_MASK = 6'h3F;
  localparam logic [1:0] CTC_MODE_CMP = 2'h0;
  localparam logic [1:0] CTC_IO_LOW = 2'h1;
  localparam logic [1:0] CTC_IO_HIGH = 2'h2;
  localparam logic [1:0] CTC_IO_TOG = 2'h3;
  typedef enum logic [2:0] {
    CTC_CK_SYS_DIV4, CTC_CK_SYS, CTC_CK_H_DIV16, CTC_CK_H_DIV64,
    CTC_CK_SUB0, CTC_CK_SUB1, CTC_CK_EXT_RISE, CTC_CK_EXT_FALL
  } ctc_clk_sel_t;
endpackage

// ---- ctc_timer.sv ----
// Compact timer core with classic Wishbone register slave
`timescale 1ns/100ps
module ctc_timer (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Clock sources and pins
  input wire logic i_sub_clock_tick,
  input wire logic i_ext_clock_pin,
  output logic o_timer_out_pin,
  output logic o_timer_out_pin_inverted,
  // Request flags
  output logic o_compare_a_flag,
  output logic o_period_match_flag
);
  import ctc_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [7:0] ctrl_a_ff;
  logic [7:0] ctrl_b_ff;
  logic [9:0] cnt_ff;
  logic [9:0] cmpa_ff;
  logic [7:0] buf_ff;
  logic [5:0] div_ff;
  logic ext_prev_ff;
  logic on_prev_ff;
  logic out_lvl_ff;
  logic flag_a_ff;
  logic flag_p_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ref_adr);
    hit = (adr == ref_adr);
  endfunction

  wire logic acc = i_wb_cyc & i_wb_stb & ~ack_ff;
  wire logic wr = acc & i_wb_we & i_wb_sel[0];
  wire logic rd = acc & ~i_wb_we;
  wire logic [7:0] wd = i_wb_dat[7:0];
  wire logic wr_ctrl_a = wr & hit(i_wb_adr, CTC_ADR_CTRL_A);
  wire logic wr_ctrl_b = wr & hit(i_wb_adr, CTC_ADR_CTRL_B);
  // Count pair takes no write path at all
  wire logic wr_cmpa_lo = wr & hit(i_wb_adr, CTC_ADR_CMPA_LO);
  wire logic wr_cmpa_hi = wr & hit(i_wb_adr, CTC_ADR_CMPA_HI);
  wire logic wr_flags = wr & hit(i_wb_adr, CTC_ADR_FLAGS);
  wire logic rd_cnt_hi = rd & hit(i_wb_adr, CTC_ADR_CNT_HI);
  wire logic rd_cmpa_hi = rd & hit(i_wb_adr, CTC_ADR_CMPA_HI);

  // ------------------------------------------------------------
  // Field views
  // ------------------------------------------------------------
  wire logic pause = ctrl_a_ff[CTC_A_PAUSE];
  wire logic counter_on = ctrl_a_ff[CTC_A_ON];
  wire ctc_clk_sel_t clk_sel = ctc_clk_sel_t'(ctrl_a_ff[CTC_A_CLK_HI:CTC_A_CLK_LO]);
  wire logic [2:0] period_val = ctrl_a_ff[CTC_A_PER_HI:CTC_A_PER_LO];
  wire logic [1:0] mode = ctrl_b_ff[CTC_B_MODE_HI:CTC_B_MODE_LO];
  wire logic [1:0] io_sel = ctrl_b_ff[CTC_B_IO_HI:CTC_B_IO_LO];
  wire logic init_lvl = ctrl_b_ff[CTC_B_INIT];
  wire logic polarity = ctrl_b_ff[CTC_B_POL];
  wire logic clear_sel = ctrl_b_ff[CTC_B_CLR_SEL];
  wire logic on_rise = counter_on & ~on_prev_ff;

  // ------------------------------------------------------------
  // Clock source selection
  // ------------------------------------------------------------
  // High clock is taken as the bus clock; sub clock arrives as a strobe
  wire logic ext_rise = i_ext_clock_pin & ~ext_prev_ff;
  wire logic ext_fall = ~i_ext_clock_pin & ext_prev_ff;
  logic src_tick;
  always_comb begin
    case (clk_sel)
      CTC_CK_SYS_DIV4: src_tick = (div_ff[1:0] == CTC_DIV4_MASK[1:0]);
      CTC_CK_SYS: src_tick = 1'b1;
      CTC_CK_H_DIV16: src_tick = (div_ff[3:0] == CTC_DIV16_MASK[3:0]);
      CTC_CK_H_DIV64: src_tick = (div_ff == CTC_DIV64_MASK);
      CTC_CK_SUB0, CTC_CK_SUB1: src_tick = i_sub_clock_tick;
      CTC_CK_EXT_RISE: src_tick = ext_rise;
      CTC_CK_EXT_FALL: src_tick = ext_fall;
      default: src_tick = 1'b0;
    endcase
  end

  // Off or paused: no tick, count held
  wire logic tick = src_tick & counter_on & ~pause & ~on_rise;

  // ------------------------------------------------------------
  // Comparators
  // ------------------------------------------------------------
  wire logic [9:0] cnt_inc = cnt_ff + 10'h001;
  wire logic overflow = tick & (cnt_ff == CTC_CNT_MAX);
  // Next value checked so code n clears after n*128 clocks
  wire logic per_hit = tick & (period_val != 3'h0) & (cnt_inc[9:7] == period_val);
  wire logic a_hit = tick & (cmpa_ff != CTC_CNT_RST) & (cnt_inc == cmpa_ff);
  // Period zero: overflow stands in for the period match
  wire logic per_event = ~clear_sel & (per_hit | (overflow & period_val == 3'h0));
  wire logic clr_match = clear_sel ? a_hit : per_event;

  // ------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------
  logic [9:0] nxt_cnt;
  always_comb begin
    if (on_rise) begin
      nxt_cnt = CTC_CNT_RST;
    end else if (clr_match) begin
      nxt_cnt = CTC_CNT_RST;
    end else if (tick) begin
      nxt_cnt = cnt_inc;
    end else begin
      nxt_cnt = cnt_ff;
    end
  end

  // ------------------------------------------------------------
  // Output pin level
  // ------------------------------------------------------------
  logic nxt_out_lvl;
  always_comb begin
    nxt_out_lvl = out_lvl_ff;
    if (on_rise) begin
      nxt_out_lvl = init_lvl;
    end else if (a_hit & (mode == CTC_MODE_CMP)) begin
      case (io_sel)
        CTC_IO_LOW: nxt_out_lvl = 1'b0;
        CTC_IO_HIGH: nxt_out_lvl = 1'b1;
        CTC_IO_TOG: nxt_out_lvl = ~out_lvl_ff;
        default: nxt_out_lvl = out_lvl_ff;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Flags: set wins over a same-cycle clear
  // ------------------------------------------------------------
  wire logic nxt_flag_a = a_hit | (flag_a_ff & ~(wr_flags & wd[CTC_F_CMPA]));
  wire logic nxt_flag_p = per_event | (flag_p_ff & ~(wr_flags & wd[CTC_F_PER]));

  // ------------------------------------------------------------
  // Shared low-byte buffer
  // ------------------------------------------------------------
  logic [7:0] nxt_buf;
  always_comb begin
    if (wr_cmpa_lo) begin
      nxt_buf = wd;
    end else if (rd_cnt_hi) begin
      nxt_buf = cnt_ff[7:0];
    end else if (rd_cmpa_hi) begin
      nxt_buf = cmpa_ff[7:0];
    end else begin
      nxt_buf = buf_ff;
    end
  end

  // High write lands high byte and buffer together
  wire logic [9:0] nxt_cmpa = wr_cmpa_hi ? {wd[1:0], buf_ff} : cmpa_ff;

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  logic [7:0] rsel;
  always_comb begin
    case (i_wb_adr)
      CTC_ADR_CTRL_A: rsel = ctrl_a_ff;
      CTC_ADR_CTRL_B: rsel = ctrl_b_ff;
      CTC_ADR_CNT_LO: rsel = buf_ff;
      CTC_ADR_CNT_HI: rsel = {6'h00, cnt_ff[9:8]};
      CTC_ADR_CMPA_LO: rsel = buf_ff;
      CTC_ADR_CMPA_HI: rsel = {6'h00, cmpa_ff[9:8]};
      CTC_ADR_FLAGS: rsel = {6'h00, flag_p_ff, flag_a_ff};
      default: rsel = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ctrl_a_ff <= CTC_CTRL_RST;
      ctrl_b_ff <= CTC_CTRL_RST;
      cnt_ff <= CTC_CNT_RST;
      cmpa_ff <= CTC_CNT_RST;
      buf_ff <= 8'h00;
      div_ff <= 6'h00;
      ext_prev_ff <= 1'b0;
      on_prev_ff <= 1'b0;
      out_lvl_ff <= 1'b0;
      flag_a_ff <= 1'b0;
      flag_p_ff <= 1'b0;
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else begin
      ctrl_a_ff <= wr_ctrl_a ? wd : ctrl_a_ff;
      ctrl_b_ff <= wr_ctrl_b ? wd : ctrl_b_ff;
      cnt_ff <= nxt_cnt;
      cmpa_ff <= nxt_cmpa;
      buf_ff <= nxt_buf;
      div_ff <= div_ff + 6'h01;
      ext_prev_ff <= i_ext_clock_pin;
      on_prev_ff <= counter_on;
      out_lvl_ff <= nxt_out_lvl;
      flag_a_ff <= nxt_flag_a;
      flag_p_ff <= nxt_flag_p;
      ack_ff <= acc;
      rdat_ff <= rd ? {24'h00_0000, rsel} : rdat_ff;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Polarity applies to both pins; pin routing is left to software
  assign o_timer_out_pin = out_lvl_ff ^ polarity;
  assign o_timer_out_pin_inverted = ~(out_lvl_ff ^ polarity);
  assign o_compare_a_flag = flag_a_ff;
  assign o_period_match_flag = flag_p_ff;
  assign o_wb_ack = ack_ff;
  assign o_wb_dat = rdat_ff;
endmodule // ctc_timer

// ---- ctc_timer_props.sv ----
// Concurrent checks on the compact timer core ports
`timescale 1ns/100ps
module ctc_timer_props
  import ctc_pkg::*;
(
  // Clock, reset and bus
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  // Timer pins and flags
  input wire logic i_sub_clock_tick,
  input wire logic i_ext_clock_pin,
  input wire logic o_timer_out_pin,
  input wire logic o_timer_out_pin_inverted,
  input wire logic o_compare_a_flag,
  input wire logic o_period_match_flag
);
  // ------------------------------------------------------------
  // Shadow of the written control bits
  // ------------------------------------------------------------
  logic take;
  logic wr0;
  logic fclr;
  logic [7:0] adr_ff;
  logic [7:0] b_ff;
  logic on_ff;
  assign take = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wr0 = take && i_wb_we && i_wb_sel[0];
  assign fclr = wr0 && (i_wb_adr == CTC_ADR_FLAGS);
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      adr_ff <= 8'h00;
      b_ff <= 8'h00;
      on_ff <= 1'b0;
    end else begin
      if (take) adr_ff <= i_wb_adr;
      if (wr0 && i_wb_adr == CTC_ADR_CTRL_B) b_ff <= i_wb_dat[7:0];
      if (wr0 && i_wb_adr == CTC_ADR_CTRL_A) on_ff <= i_wb_dat[CTC_A_ON];
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence s_one_ack;
    o_wb_ack ##1 !o_wb_ack;
  endsequence
  property p_ack; take |=> s_one_ack; endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle");
  property p_dat_hi; o_wb_ack |-> o_wb_dat[31:8] == 24'h00_0000; endproperty
  a_dat_hi: assert property (p_dat_hi) else $error("read data upper nonzero");
  property p_unmap; o_wb_ack && !i_wb_we && adr_ff > CTC_ADR_FLAGS |-> o_wb_dat == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
  property p_inv; o_timer_out_pin_inverted != o_timer_out_pin; endproperty
  a_inv: assert property (p_inv) else $error("pin pair not complementary");
  property p_a_hold; o_compare_a_flag && !(fclr && i_wb_dat[0]) |=> o_compare_a_flag; endproperty
  a_a_hold: assert property (p_a_hold) else $error("A flag dropped");
  property p_p_hold; o_period_match_flag && !(fclr && i_wb_dat[1]) |=> $stable(o_period_match_flag);
  endproperty
  a_p_hold: assert property (p_p_hold) else $error("period flag dropped");
  property p_no_per; b_ff[0] && !o_period_match_flag |=> !o_period_match_flag; endproperty
  a_no_per: assert property (p_no_per) else $error("period flag with A clear");
  sequence s_on_rise;
    wr0 && i_wb_adr == CTC_ADR_CTRL_A && i_wb_dat[CTC_A_ON] && !on_ff && b_ff[7:6] == CTC_MODE_CMP;
  endsequence
  property p_on_rise; s_on_rise |-> ##2 o_timer_out_pin == (b_ff[3] ^ b_ff[2]); endproperty
  a_on_rise: assert property (p_on_rise) else $error("pin not at initial level");
endmodule // ctc_timer_props
bind ctc_timer ctc_timer_props ctc_timer_props_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
  .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
  .i_sub_clock_tick(i_sub_clock_tick), .i_ext_clock_pin(i_ext_clock_pin),
  .o_timer_out_pin(o_timer_out_pin), .o_timer_out_pin_inverted(o_timer_out_pin_inverted),
  .o_compare_a_flag(o_compare_a_flag), .o_period_match_flag(o_period_match_flag));

// ---- testbench.sv ----
// Self-checking testbench for the compact timer core
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
  import ctc_pkg::*;
  logic i_mclk = 0, i_rst_n = 0, cyc = 0, stb = 0, we = 0, sub = 0, pin = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, o_wb_dat;
  logic o_wb_ack, tp, tpb, fa, fp;
  int bad_count = 0, n_compared = 0;
  always #4 i_mclk = ~i_mclk;
  always @(posedge i_mclk) sub <= ~sub;
  ctc_timer ctc_timer_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'h1), .i_wb_dat(wdat), .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack), .i_sub_clock_tick(sub), .i_ext_clock_pin(pin), .o_timer_out_pin(tp),
    .o_timer_out_pin_inverted(tpb), .o_compare_a_flag(fa), .o_period_match_flag(fp));
  // ------------------------------------------------------------
  // Bus and pin helpers
  // ------------------------------------------------------------
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge i_mclk);
    {cyc, stb, we, adr} <= {2'b11, w, a};
    wdat <= {24'h00_0000, d};
    // No local limit: a slave that never answers is caught by the watchdog
    do begin @(posedge i_mclk); end while (o_wb_ack !== 1'b1);
    q = o_wb_dat[7:0];
    {cyc, stb} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    `CHK(nm, e, q)
  endtask
  // High byte first so the low byte comes back through the buffer
  task automatic rdcnt(output logic [9:0] c);
    logic [7:0] h, l;
    wb(1'b0, CTC_ADR_CNT_HI, 8'h00, h);
    wb(1'b0, CTC_ADR_CNT_LO, 8'h00, l);
    c = {h[1:0], l};
  endtask
  // Pin is driven straight into the core, as if already routed to the timer
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge i_mclk) pin <= 1'b1;
      repeat (3) @(posedge i_mclk);
      pin <= 1'b0;
      repeat (3) @(posedge i_mclk);
    end
  endtask
  task automatic ext_step(input logic [7:0] ca, input int n, input logic [9:0] e);
    logic [9:0] c;
    wr(CTC_ADR_CTRL_A, ca);
    pulses(n);
    rdcnt(c);
    `CHK("ext_count", e, c)
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    rdc("ctrl_a_rst", CTC_ADR_CTRL_A, 8'h00);
    rdc("flags_rst", CTC_ADR_FLAGS, 8'h00);
    `CHK("pin_rst", 2'b01, {tp, tpb})
    wr(CTC_ADR_CMPA_LO, 8'h5A);
    wr(CTC_ADR_CMPA_HI, 8'h03);
    rdc("cmpa_hi", CTC_ADR_CMPA_HI, 8'h03);
    rdc("cmpa_lo", CTC_ADR_CMPA_LO, 8'h5A);
    wr(CTC_ADR_CNT_HI, 8'h03);
    rdc("cnt_ro", CTC_ADR_CNT_HI, 8'h00);
    wr(8'h1C, 8'hFF);
    rdc("unmapped", 8'h1C, 8'h00);
    $display("registers test done");
  endtask
  task automatic t_ext();
    ext_step(8'h68, 3, 10'h003);
    ext_step(8'h78, 2, 10'h005);
    ext_step(8'hF8, 2, 10'h005);
    ext_step(8'h78, 1, 10'h006);
    ext_step(8'h70, 1, 10'h006);
    ext_step(8'h78, 0, 10'h000);
    $display("external clock test done");
  endtask
  task automatic t_per();
    logic [9:0] c;
    wr(CTC_ADR_CTRL_A, 8'h70);
    wr(CTC_ADR_FLAGS, 8'h03);
    wr(CTC_ADR_CTRL_A, 8'h19);
    repeat (100) @(posedge i_mclk);
    rdc("per_early", CTC_ADR_FLAGS, 8'h00);
    repeat (40) @(posedge i_mclk);
    rdc("per_flag", CTC_ADR_FLAGS, 8'h02);
    rdcnt(c);
    `CHK("per_clear", 3'h0, c[9:7])
    $display("period test done");
  endtask
  task automatic t_cmpa();
    logic [9:0] c;
    wr(CTC_ADR_CTRL_A, 8'h10);
    wr(CTC_ADR_CMPA_LO, 8'h05);
    wr(CTC_ADR_CMPA_HI, 8'h00);
    wr(CTC_ADR_CTRL_B, 8'h21);
    wr(CTC_ADR_FLAGS, 8'h03);
    wr(CTC_ADR_CTRL_A, 8'h1F);
    repeat (20) @(posedge i_mclk);
    rdc("a_only", CTC_ADR_FLAGS, 8'h01);
    `CHK("pin_high", 1'b1, tp)
    rdcnt(c);
    `CHK("a_clear", 1'b1, c < 10'h005)
    wr(CTC_ADR_CTRL_A, 8'h10);
    wr(CTC_ADR_CMPA_LO, 8'h00);
    wr(CTC_ADR_CMPA_HI, 8'h00);
    wr(CTC_ADR_FLAGS, 8'h03);
    wr(CTC_ADR_CTRL_A, 8'h1F);
    repeat (1100) @(posedge i_mclk);
    rdc("no_a_flag", CTC_ADR_FLAGS, 8'h00);
    `CHK("pin_init", 1'b0, tp)
    $display("compare A test done");
  endtask
  // On, wait, pause: 129 bus clocks elapse between the on and pause edges
  task automatic div_step(input logic [2:0] k, input logic [9:0] e);
    logic [9:0] c;
    wr(CTC_ADR_CTRL_A, {1'b0, k, 4'h0});
    wr(CTC_ADR_CTRL_A, {1'b0, k, 4'h8});
    repeat (126) @(posedge i_mclk);
    wr(CTC_ADR_CTRL_A, {1'b1, k, 4'h8});
    rdcnt(c);
    `CHK("div_count", e, c)
  endtask
  task automatic t_div();
    div_step(3'h0, 10'h020);
    div_step(3'h1, 10'h080);
    div_step(3'h2, 10'h008);
    div_step(3'h3, 10'h002);
    div_step(3'h4, 10'h040);
    $display("clock divider test done");
  endtask
  task automatic t_tog();
    wr(CTC_ADR_CTRL_A, 8'h60);
    wr(CTC_ADR_CMPA_LO, 8'h02);
    wr(CTC_ADR_CMPA_HI, 8'h00);
    wr(CTC_ADR_CTRL_B, 8'h35);
    wr(CTC_ADR_CTRL_A, 8'h68);
    @(posedge i_mclk);
    `CHK("pol_init", 2'b10, {tp, tpb})
    pulses(2);
    `CHK("toggle_1", 2'b01, {tp, tpb})
    pulses(2);
    `CHK("toggle_2", 2'b10, {tp, tpb})
    $display("toggle test done");
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Run is about 2200 cycles; the watchdog leaves ample margin
  initial begin
    #160000;
    bad_count++;
    end_sim();
  end
  initial begin
    repeat (4) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    t_regs();
    t_ext();
    t_per();
    t_cmpa();
    t_div();
    t_tog();
    end_sim();
  end
endmodule // testbench
